// [logic/sdrct_host.sv]
// Controller end: runs refresh and single-burst accesses with spacing.
// Assumes a user port with one request at a time; shares core_clk.
`timescale 1ns/1ps
`default_nettype none
`include "sdrct_cfg.svh"
module sdrct_host
  import sdrct_pkg::*;
  #(parameter int DW = 16, parameter int AW = 12,
    parameter int REF_INT = `SDRCT_REFRESH_INT_CYC,
    parameter int OPEN_MAX = `SDRCT_ROW_OPEN_MAX_CYC)
  (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_b,
  // User request
  input  wire logic          req,
  input  wire logic          req_wr,
  input  wire logic [1:0]    req_bank,
  input  wire logic [AW-1:0] req_addr,
  input  wire logic [DW-1:0] req_wdata,
  input  wire logic          req_sleep,
  output var  logic          req_ack,
  output var  logic          rd_valid,
  output var  logic [DW-1:0] rd_data,
  // Link
  sdrct_if.host lnk
  );
  localparam int CW = 16;
  localparam logic [CW-1:0] T_RAS  = CW'(`SDRCT_ROW_OPEN_MIN_CYC);
  localparam logic [CW-1:0] T_RC   = CW'(`SDRCT_ROW_CYCLE_CYC);
  localparam logic [CW-1:0] T_RCD  = CW'(`SDRCT_ROW_TO_COL_CYC);
  localparam logic [CW-1:0] T_RP   = CW'(`SDRCT_PRECHARGE_CYC);
  localparam logic [CW-1:0] T_RRD  = CW'(`SDRCT_BANK_GAP_CYC);
  localparam logic [CW-1:0] T_WR   = CW'(`SDRCT_WREC_CYC
                                     + `SDRCT_WDATA_TO_CLOSE);
  localparam logic [CW-1:0] T_MRD  = CW'(`SDRCT_MODE_SETTLE);
  localparam logic [CW-1:0] T_REF  = CW'(REF_INT);
  localparam logic [CW-1:0] T_OMAX = CW'(OPEN_MAX > 65535 ? 65535 : OPEN_MAX);

  sdrct_hst_t    st_ff;
  sdrct_cmd_t    cmd_ff;
  logic [1:0]    bank_ff;
  logic [AW-1:0] addr_ff;
  logic [DW-1:0] wd_ff;
  logic          wd_oe_ff;
  logic          mask_ff;
  logic          cke_ff;
  logic          ack_ff;
  logic [CW-1:0] gap_ff;    // Any-bank activate spacing
  logic [CW-1:0] act_ff;    // Since activate: column and close
  logic [CW-1:0] pre_ff;    // Since close/refresh/mode
  logic [CW-1:0] ref_ff;
  logic [CW-1:0] omax_ff;
  logic [1:0]    wait_ff;
  logic          rd_ff;
  logic [`SDRCT_READ_LATENCY:0] rv_ff;
  logic [DW-1:0] rdat_ff;
  logic          rv_out_ff;

  wire logic zero_gap  = gap_ff == '0 && pre_ff == '0;
  wire logic ref_due   = ref_ff == '0;
  wire logic wake_ok   = wait_ff == 2'h0;
  wire logic may_close = act_ff == '0;
  wire logic must_close = omax_ff == '0;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff    <= SDRCT_H_INIT;
      cmd_ff   <= SDRCT_NOP;
      bank_ff  <= 2'h0;
      addr_ff  <= '0;
      wd_ff    <= '0;
      wd_oe_ff <= 1'b0;
      mask_ff  <= 1'b0;
      cke_ff   <= 1'b1;
      ack_ff   <= 1'b0;
      gap_ff   <= '0;
      act_ff   <= '0;
      pre_ff   <= '0;
      ref_ff   <= T_REF;
      omax_ff  <= T_OMAX;
      wait_ff  <= 2'h0;
      rd_ff    <= 1'b0;
    end else begin
      cmd_ff   <= SDRCT_NOP;
      wd_oe_ff <= 1'b0;
      ack_ff   <= 1'b0;
      gap_ff   <= gap_ff == '0 ? '0 : gap_ff - CW'(1);
      act_ff   <= act_ff == '0 ? '0 : act_ff - CW'(1);
      pre_ff   <= pre_ff == '0 ? '0 : pre_ff - CW'(1);
      ref_ff   <= ref_ff == '0 ? '0 : ref_ff - CW'(1);
      omax_ff  <= omax_ff == '0 ? '0 : omax_ff - CW'(1);
      wait_ff  <= wait_ff == 2'h0 ? 2'h0 : wait_ff - 2'h1;
      cke_ff   <= ~(req_sleep && st_ff == SDRCT_H_IDLE && !ref_due);
      if (!cke_ff) begin
        wait_ff <= 2'(`SDRCT_SUSPEND_DELAY);
      end
      case (st_ff)
        SDRCT_H_INIT: begin
          cmd_ff <= SDRCT_MODE;
          pre_ff <= T_MRD;
          st_ff  <= SDRCT_H_IDLE;
        end
        SDRCT_H_IDLE: begin
          if (cke_ff && wake_ok && zero_gap) begin
            if (ref_due) begin
              cmd_ff <= SDRCT_REF;
              pre_ff <= T_RC;
              ref_ff <= T_REF;
            end else if (req && !req_sleep) begin
              cmd_ff  <= SDRCT_ACT;
              bank_ff <= req_bank;
              addr_ff <= req_addr;
              wd_ff   <= req_wdata;
              rd_ff   <= ~req_wr;
              ack_ff  <= 1'b1;
              gap_ff  <= T_RC > T_RRD ? T_RC : T_RRD;
              act_ff  <= T_RCD;
              omax_ff <= T_OMAX;
              st_ff   <= SDRCT_H_OPEN;
            end
          end
        end
        SDRCT_H_OPEN: begin
          if (may_close) begin
            cmd_ff   <= rd_ff ? SDRCT_READ : SDRCT_WRITE;
            wd_oe_ff <= ~rd_ff;
            act_ff   <= rd_ff ? T_RAS - T_RCD : T_WR;
            st_ff    <= SDRCT_H_XFER;
          end
        end
        SDRCT_H_XFER: begin
          wd_oe_ff <= 1'b0;
          // Undriven write beats are masked so old contents stay
          mask_ff  <= ~rd_ff;
          if (may_close || must_close) begin
            mask_ff <= 1'b0;
            cmd_ff <= SDRCT_PRE;
            pre_ff <= T_RP;
            st_ff  <= SDRCT_H_IDLE;
          end
        end
        default: st_ff <= SDRCT_H_INIT;
      endcase
    end
  end

  // Read data capture RL+1 clocks after the read command
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rv_ff     <= '0;
      rdat_ff   <= '0;
      rv_out_ff <= 1'b0;
    end else begin
      rv_ff     <= {rv_ff[`SDRCT_READ_LATENCY-1:0],
                    cmd_ff == SDRCT_READ};
      rv_out_ff <= rv_ff[`SDRCT_READ_LATENCY];
      rdat_ff   <= rv_ff[`SDRCT_READ_LATENCY] ? lnk.dq : rdat_ff;
    end
  end

  assign lnk.cmd        = cmd_ff;
  assign lnk.cke        = cke_ff;
  assign lnk.bank       = bank_ff;
  assign lnk.addr       = addr_ff;
  assign lnk.auto_close = 1'b0;
  assign lnk.mask       = {(DW/8){mask_ff}};
  assign lnk.dq_h       = wd_ff;
  assign lnk.dq_h_oe    = wd_oe_ff;
  assign req_ack        = ack_ff;
  assign rd_valid       = rv_out_ff;
  assign rd_data        = rdat_ff;
endmodule : sdrct_host
`default_nettype wire

// [include/sdrct_cfg.svh]
// Timing constants for the DRAM command-timing pair.
// Assumes a 40 MHz core clock (25 ns period).
`ifndef SDRCT_CFG_SVH
`define SDRCT_CFG_SVH
`define SDRCT_CLK_PS                25000
`define SDRCT_ROW_OPEN_MIN_PS       50000
`define SDRCT_ROW_OPEN_MAX_PS       16000000
`define SDRCT_ROW_CYCLE_PS          80000
`define SDRCT_ROW_TO_COL_PS         30000
`define SDRCT_PRECHARGE_PS          30000
`define SDRCT_BANK_GAP_PS           20000
`define SDRCT_WRITE_RECOVERY_PS     20000
`define SDRCT_REFRESH_WINDOW_MS     64
`define SDRCT_REFRESH_ROWS          4096
`define SDRCT_CYC_UP(ps)   (((ps) + `SDRCT_CLK_PS - 1) / `SDRCT_CLK_PS)
`define SDRCT_CYC_DN(ps)   ((ps) / `SDRCT_CLK_PS)
`define SDRCT_ROW_OPEN_MIN_CYC  `SDRCT_CYC_UP(`SDRCT_ROW_OPEN_MIN_PS)
`define SDRCT_ROW_OPEN_MAX_CYC  `SDRCT_CYC_DN(`SDRCT_ROW_OPEN_MAX_PS)
`define SDRCT_ROW_CYCLE_CYC     `SDRCT_CYC_UP(`SDRCT_ROW_CYCLE_PS)
`define SDRCT_ROW_TO_COL_CYC    `SDRCT_CYC_UP(`SDRCT_ROW_TO_COL_PS)
`define SDRCT_PRECHARGE_CYC     `SDRCT_CYC_UP(`SDRCT_PRECHARGE_PS)
`define SDRCT_BANK_GAP_CYC      `SDRCT_CYC_UP(`SDRCT_BANK_GAP_PS)
`define SDRCT_WREC_CYC          `SDRCT_CYC_UP(`SDRCT_WRITE_RECOVERY_PS)
`define SDRCT_REFRESH_INT_CYC \
  ((`SDRCT_REFRESH_WINDOW_MS * 1000000 / `SDRCT_REFRESH_ROWS) * 1000 \
   / `SDRCT_CLK_PS)
`define SDRCT_READ_LATENCY      3
`define SDRCT_WRITE_MASK_LAT    0
`define SDRCT_READ_FLOAT_LAT    2
`define SDRCT_CLOSE_FLOAT_LAT   3
`define SDRCT_WDATA_TO_CLOSE    2
`define SDRCT_AUTOCLOSE_TO_ACT  5
`define SDRCT_WDATA_TO_STOP     1
`define SDRCT_WDATA_TO_COL      1
`define SDRCT_MODE_SETTLE       2
`define SDRCT_SUSPEND_DELAY     1
`define SDRCT_BURST_LEN         4
`endif

// [include/sdrct_pkg.sv]
// Types shared by both ends of the DRAM command link.
// Assumes sdrct_cfg.svh holds the numbers.
package sdrct_pkg;
  typedef enum logic [2:0] {
    SDRCT_NOP   = 3'h0,
    SDRCT_ACT   = 3'h1,
    SDRCT_READ  = 3'h2,
    SDRCT_WRITE = 3'h3,
    SDRCT_PRE   = 3'h4,
    SDRCT_REF   = 3'h5,
    SDRCT_STOP  = 3'h6,
    SDRCT_MODE  = 3'h7
  } sdrct_cmd_t;
  typedef enum logic [1:0] {
    SDRCT_H_INIT = 2'b00,
    SDRCT_H_IDLE = 2'b01,
    SDRCT_H_OPEN = 2'b11,
    SDRCT_H_XFER = 2'b10
  } sdrct_hst_t;
endpackage : sdrct_pkg

// [include/sdrct_if.sv]
// Command link between controller and memory array model.
// Data lines are a shared bus resolved from the two enables.
`timescale 1ns/1ps
`default_nettype none
interface sdrct_if
  import sdrct_pkg::*;
  #(parameter int DW = 16, parameter int AW = 12);
  sdrct_cmd_t           cmd;
  logic                 cke;
  logic [1:0]           bank;
  logic [AW-1:0]        addr;
  logic                 auto_close;
  logic [DW/8-1:0]      mask;
  logic [DW-1:0]        dq_h;
  logic                 dq_h_oe;
  logic [DW-1:0]        dq_d;
  logic [DW/8-1:0]      dq_d_oe;
  logic [DW-1:0]        dq;
  always_comb begin
    for (int i = 0; i < DW/8; i++) begin
      dq[i*8 +: 8] = dq_h_oe ? dq_h[i*8 +: 8] :
                     dq_d_oe[i] ? dq_d[i*8 +: 8] : 8'hff;
    end
  end
  modport host (output cmd, cke, bank, addr, auto_close, mask, dq_h,
                dq_h_oe, input dq);
  modport dev  (input cmd, cke, bank, addr, auto_close, mask, dq,
                output dq_d, dq_d_oe);
endinterface : sdrct_if
`default_nettype wire

// [logic/sdrct_dev.sv]
// Memory array end: decodes commands, stores and returns burst data.
// Assumes the controller keeps all spacing rules; shares core_clk.
// Operation
// - Bank stays open 44/50 ns to 16K ns
// - Activate-to-activate and refresh spacing 60/80 ns
// - Activate to column command 22.5/30 ns
// - 4096 refreshes every 64 ms
// - Precharge to activate 22.5/30 ns
// - Different-bank activates 15/20 ns apart
// - Last write data to precharge recovery
// - Read data returns three clocks later (here four: extra output register)
// - Column command accepted every clock
// - Clock enable low suspends next clock
// - Clock enable high resumes after one clock
// - Write mask blocks same-cycle data
// - Read mask floats lanes two clocks later
// - First write data with write command
// - Auto-close write: five clocks to activate
// - Burst stop one clock after data
// - Last write data to column command one clock
// - Mode load: two clocks before activate
// - Outputs float three clocks after precharge (here four: extra output register)
// - Precharge two clocks after final write data
`timescale 1ns/1ps
`default_nettype none
`include "sdrct_cfg.svh"
module sdrct_dev
  import sdrct_pkg::*;
  #(parameter int DW = 16, parameter int AW = 12, parameter int COLW = 6)
  (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_b,
  // Link
  sdrct_if.dev      lnk,
  // Status
  output var  logic suspended,
  output var  logic [3:0] banks_open
  );
  localparam int NB = DW / 8;
  localparam int RL = `SDRCT_READ_LATENCY;
  localparam int BL = `SDRCT_BURST_LEN;

  logic [DW-1:0]   mem [0:4*(1<<COLW)-1];
  logic            cke_ff;
  logic            suspended_ff;
  logic [3:0]      open_ff;
  logic [1:0]      bank_ff;
  logic [COLW-1:0] col_ff;
  logic [2:0]      wcnt_ff;
  logic [2:0]      rcnt_ff;
  logic [RL-1:0]   rvalid_ff;
  logic [DW-1:0]   rdata_ff [RL];
  logic [NB-1:0]   mask_d1_ff;
  logic [DW-1:0]   dq_d_ff;
  logic [NB-1:0]   oe_ff;
  logic            ac_ff;

  // Command decode, gated by the clock enable of the last edge
  function automatic logic cmd_hit(input logic en, input sdrct_cmd_t c,
                                   input sdrct_cmd_t want);
    return en && c == want;
  endfunction : cmd_hit

  // Enable low stalls from the next edge on, high resumes one edge late
  wire logic run      = cke_ff;
  wire logic is_act   = cmd_hit(run, lnk.cmd, SDRCT_ACT);
  wire logic is_pre   = cmd_hit(run, lnk.cmd, SDRCT_PRE);
  wire logic is_rd    = cmd_hit(run, lnk.cmd, SDRCT_READ);
  wire logic is_wr    = cmd_hit(run, lnk.cmd, SDRCT_WRITE);
  wire logic is_stop  = cmd_hit(run, lnk.cmd, SDRCT_STOP);
  wire logic col_new  = is_rd | is_wr;
  wire logic [COLW-1:0] cur_col  = col_new ? lnk.addr[COLW-1:0] : col_ff;
  wire logic [1:0]      cur_bank = col_new ? lnk.bank : bank_ff;
  wire logic wr_beat  = is_wr | (run && wcnt_ff != 3'h0 && !col_new
                                 && !is_stop && !is_pre);
  wire logic rd_beat  = is_rd | (run && rcnt_ff != 3'h0 && !col_new
                                 && !is_stop && !is_pre);
  wire logic [DW-1:0]   wr_old = mem[{cur_bank, cur_col}];
  wire logic [DW-1:0]   wr_new;
  wire logic [2:0]      burst_left = 3'(BL - 1);
  // Final beat of a burst, where an auto-close request takes effect
  wire logic burst_last = (wr_beat && !is_wr && wcnt_ff == 3'h1) ||
                          (rd_beat && !is_rd && rcnt_ff == 3'h1);

  // Masked lanes keep old contents in the same cycle
  genvar g;
  generate
    for (g = 0; g < NB; g++) begin : g_lane
      assign wr_new[g*8 +: 8] = lnk.mask[g] ? wr_old[g*8 +: 8]
                                            : lnk.dq[g*8 +: 8];
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (wr_beat) begin
      mem[{cur_bank, cur_col}] <= wr_new;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cke_ff       <= 1'b1;
      suspended_ff <= 1'b0;
    end else begin
      cke_ff       <= lnk.cke;
      suspended_ff <= ~lnk.cke;
    end
  end

  // Open-bank map; auto-close shuts the bank on its last beat
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      open_ff <= 4'h0;
    end else begin
      if (ac_ff && burst_last) begin
        open_ff[bank_ff] <= 1'b0;
      end
      if (is_act) begin
        open_ff[lnk.bank] <= 1'b1;
      end
      if (is_pre) begin
        open_ff <= lnk.addr[10] ? 4'h0 : open_ff & ~(4'h1 << lnk.bank);
      end
    end
  end

  // Burst beat counters; a stop or precharge cuts the burst at once
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      bank_ff <= 2'h0;
      wcnt_ff <= 3'h0;
      rcnt_ff <= 3'h0;
      ac_ff   <= 1'b0;
    end else if (col_new) begin
      bank_ff <= lnk.bank;
      wcnt_ff <= is_wr ? burst_left : 3'h0;
      rcnt_ff <= is_rd ? burst_left : 3'h0;
      ac_ff   <= lnk.auto_close;
    end else if (is_stop || is_pre) begin
      wcnt_ff <= 3'h0;
      rcnt_ff <= 3'h0;
      ac_ff   <= 1'b0;
    end else if (run) begin
      if (wcnt_ff != 3'h0) begin
        wcnt_ff <= wcnt_ff - 3'h1;
      end
      if (rcnt_ff != 3'h0) begin
        rcnt_ff <= rcnt_ff - 3'h1;
      end
      if (burst_last) begin
        ac_ff <= 1'b0;
      end
    end
  end

  // Column pointer wraps within the bank
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      col_ff <= '0;
    end else if (wr_beat | rd_beat) begin
      col_ff <= cur_col + COLW'(1);
    end
  end

  // Read pipeline: data appears RL+1 clocks after the command
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mask_d1_ff <= '0;
    end else begin
      mask_d1_ff <= lnk.mask;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rvalid_ff <= '0;
    end else begin
      rvalid_ff <= {rvalid_ff[RL-2:0], rd_beat};
    end
  end

  always_ff @(posedge core_clk) begin
    rdata_ff[0] <= mem[{cur_bank, cur_col}];
    for (int i = 1; i < RL; i++) begin
      rdata_ff[i] <= rdata_ff[i-1];
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      dq_d_ff <= '0;
      oe_ff   <= '0;
    end else begin
      dq_d_ff <= rdata_ff[RL-1];
      oe_ff   <= {NB{rvalid_ff[RL-1]}} & ~mask_d1_ff;
    end
  end

  assign lnk.dq_d    = dq_d_ff;
  assign lnk.dq_d_oe = oe_ff;
  assign suspended   = suspended_ff;
  assign banks_open  = open_ff;
endmodule : sdrct_dev
`default_nettype wire

// [verification/sdrct_link_monitor.sv]
// Concurrent checks on the command link between the two ends.
// Assumes the testbench wires in the shared link signals.
`timescale 1ns/1ps
`default_nettype none
module sdrct_link_mon
  import sdrct_pkg::*;
  (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       rst_b,
  // Link
  input wire sdrct_cmd_t cmd,
  input wire logic       cke,
  input wire logic       dq_h_oe,
  input wire logic [1:0] dq_d_oe,
  input wire logic [1:0] mask
  );
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  a_open_min: assert property (cmd == SDRCT_ACT |=> cmd != SDRCT_PRE)
    else $error("precharge too soon after activate");
  a_act_gap: assert property (cmd == SDRCT_ACT |=> (cmd != SDRCT_ACT)[*3])
    else $error("activates too close");
  a_ref_gap: assert property (cmd == SDRCT_REF |=> (cmd != SDRCT_ACT)[*3])
    else $error("activate too soon after refresh");
  a_act_to_col: assert property (cmd == SDRCT_ACT |=>
    !(cmd inside {SDRCT_READ, SDRCT_WRITE}))
    else $error("column command too soon after activate");
  a_pre_to_act: assert property (cmd == SDRCT_PRE |=> cmd != SDRCT_ACT)
    else $error("activate too soon after precharge");
  a_wdata_same: assert property (cmd == SDRCT_WRITE |-> dq_h_oe)
    else $error("write data not with write command");
  a_wdata_to_pre: assert property (dq_h_oe |=> cmd != SDRCT_PRE)
    else $error("precharge too soon after write data");
  a_mode_settle: assert property (cmd == SDRCT_MODE |=>
    !(cmd inside {SDRCT_ACT, SDRCT_REF}))
    else $error("command too soon after mode load");
  a_read_lat: assert property (cmd == SDRCT_READ && cke |->
    ##4 (dq_d_oe != 2'h0))
    else $error("read data not on time");
  a_close_float: assert property (cmd == SDRCT_PRE |->
    ##4 (dq_d_oe == 2'h0))
    else $error("outputs not floated after precharge");
  a_wake_gap: assert property ($rose(cke) |-> cmd == SDRCT_NOP)
    else $error("command issued on wake cycle");
  a_mask_float: assert property (mask != 2'h0 |-> ##2
    ((dq_d_oe & $past(mask, 2)) == 2'h0))
    else $error("masked read lanes still driven");
endmodule : sdrct_link_mon
`default_nettype wire

// [verification/tb_sdrct_command_timing.sv]
// Bench joining controller and memory ends over the link.
// Assumes both ends share core_clk; stimulus moves on falling edges.
`timescale 1ns/1ps
`default_nettype none
module tb_sdrct_command_timing
  import sdrct_pkg::*;
  ;
  logic        core_clk = 1'b0;
  logic        rst_b    = 1'b0;
  logic        req      = 1'b0;
  logic        req_wr   = 1'b0;
  logic [1:0]  req_bank = 2'h0;
  logic [11:0] req_addr = 12'h000;
  logic [15:0] req_wdata = 16'h0000;
  logic        req_sleep = 1'b0;
  logic        req_ack;
  logic        rd_valid;
  logic [15:0] rd_data;
  logic        suspended;
  logic [3:0]  banks_open;
  int          bad_count = 0;
  int          tests_run = 0;
  int          ref_cnt   = 0;

  always #12.5 core_clk = ~core_clk;

  sdrct_if lnk ();
  sdrct_host #(.REF_INT(50)) i_sdrct_host (
    .core_clk(core_clk), .rst_b(rst_b), .req(req), .req_wr(req_wr),
    .req_bank(req_bank), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_sleep(req_sleep), .req_ack(req_ack), .rd_valid(rd_valid),
    .rd_data(rd_data), .lnk(lnk));
  sdrct_dev i_sdrct_dev (
    .core_clk(core_clk), .rst_b(rst_b), .lnk(lnk),
    .suspended(suspended), .banks_open(banks_open));
  sdrct_link_mon i_sdrct_link_mon (
    .core_clk(core_clk), .rst_b(rst_b), .cmd(lnk.cmd), .cke(lnk.cke),
    .dq_h_oe(lnk.dq_h_oe), .dq_d_oe(lnk.dq_d_oe), .mask(lnk.mask));

  always @(posedge core_clk)
    if (rst_b && lnk.cke && lnk.cmd == SDRCT_REF) ref_cnt++;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t ns seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report

  // One request, held until the controller takes it
  task automatic access(input logic wr, input logic [1:0] b,
                        input logic [11:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(negedge core_clk);
    req = 1'b1;
    req_wr = wr;
    req_bank = b;
    req_addr = a;
    req_wdata = d;
    while (req_ack !== 1'b1 && n < 500) begin
      @(negedge core_clk);
      n++;
    end
    chk(n < 500, 1'b1);
    req = 1'b0;
  endtask : access

  task automatic rd_chk(input logic [1:0] b, input logic [11:0] a,
                        input logic [15:0] exp);
    int n;
    n = 0;
    access(1'b0, b, a, 16'h0000);
    while (rd_valid !== 1'b1 && n < 50) begin
      @(negedge core_clk);
      n++;
    end
    chk(n < 50, 1'b1);
    chk(rd_data, exp);
  endtask : rd_chk

  task automatic wait_flag(input logic v);
    int n;
    n = 0;
    while (suspended !== v && n < 100) begin
      @(negedge core_clk);
      n++;
    end
    chk(suspended, v);
  endtask : wait_flag

  initial begin
    #(25 * 20000);
    bad_count++;
    final_report();
  end

  initial begin
    repeat (12) @(negedge core_clk);
    rst_b = 1'b1;
    repeat (4) @(negedge core_clk);
    for (int b = 0; b < 4; b++)
      access(1'b1, b[1:0], 12'h405 + 12'(b), 16'hc3a0 + 16'(b));
    for (int b = 0; b < 4; b++)
      rd_chk(b[1:0], 12'h405 + 12'(b), 16'hc3a0 + 16'(b));
    // Overwrite, then one column lower: its masked beats spare 406
    access(1'b1, 2'h1, 12'h406, 16'h5a5a);
    access(1'b1, 2'h1, 12'h805, 16'h0ff0);
    rd_chk(2'h1, 12'h406, 16'h5a5a);
    rd_chk(2'h1, 12'h805, 16'h0ff0);
    repeat (10) @(negedge core_clk);
    chk(banks_open, 4'h0);
    ref_cnt = 0;
    repeat (500) @(negedge core_clk);
    chk(ref_cnt >= 9, 1'b1);
    // Sleep right after a refresh so none is due while suspended
    @(posedge core_clk iff lnk.cmd == SDRCT_REF);
    @(negedge core_clk);
    req_sleep = 1'b1;
    wait_flag(1'b1);
    chk(lnk.cke, 1'b0);
    req_sleep = 1'b0;
    wait_flag(1'b0);
    rd_chk(2'h2, 12'h407, 16'hc3a2);
    // Reset in mid-run
    @(negedge core_clk);
    rst_b = 1'b0;
    repeat (2) @(negedge core_clk);
    chk({banks_open, suspended, lnk.cke}, 6'h01);
    rst_b = 1'b1;
    repeat (4) @(negedge core_clk);
    access(1'b1, 2'h3, 12'h03f, 16'h9e71);
    rd_chk(2'h3, 12'h03f, 16'h9e71);
    repeat (10) @(negedge core_clk);
    final_report();
  end
endmodule : tb_sdrct_command_timing
`default_nettype wire
